// ---- include/lhio_pkg.sv ----
// Package with register map, field positions, reset values and timing for the I/O control block.
package lhio_pkg;
  // Register offsets.
  localparam logic [7:0] LHIO_OFF_SCL_LOW   = 8'h0B;
  localparam logic [7:0] LHIO_OFF_RX_CTL    = 8'h0C;
  localparam logic [7:0] LHIO_OFF_IO_LEVEL_CONTROL    = 8'h0D;
  localparam logic [7:0] LHIO_OFF_PIN_STS   = 8'h0E;
  localparam logic [7:0] LHIO_OFF_PIN_INEN  = 8'h0F;
  // Reset values.
  localparam logic [7:0] LHIO_RST_SCL_LOW   = 8'h7A;
  localparam logic [1:0] LHIO_RST_RX_RSVD   = 2'h2;
  localparam logic [1:0] LHIO_RST_SRC_SEL   = 2'h0;
  localparam logic       LHIO_RST_PORT_EN   = 1'h1;
  localparam logic [3:0] LHIO_RST_IO_RSVD   = 4'h9;
  localparam logic [6:0] LHIO_RST_INEN      = 7'h7F;
  localparam logic       LHIO_RST_IO_SEL    = 1'h0;
  localparam logic       LHIO_RST_IO_OVR    = 1'h0;
  // Field positions.
  localparam int LHIO_RX_PASS_LSB   = 4;
  localparam int LHIO_RX_LOCK_LSB   = 2;
  localparam int LHIO_RX_P1_BIT     = 1;
  localparam int LHIO_RX_P0_BIT     = 0;
  localparam int LHIO_IO_SEL_BIT    = 7;
  localparam int LHIO_IO_OVR_BIT    = 6;
  localparam int LHIO_IO_MODE_LSB   = 4;
  localparam int LHIO_IO_RSVD_LSB   = 0;
  // Source select codes.
  localparam logic [1:0] LHIO_SRC_PORT0 = 2'h0;
  localparam logic [1:0] LHIO_SRC_PORT1 = 2'h1;
  localparam logic [1:0] LHIO_SRC_ANY   = 2'h2;
  localparam logic [1:0] LHIO_SRC_ALL   = 2'h3;
  // Supply mode codes.
  localparam logic [1:0] LHIO_MODE_1V8  = 2'h0;
  localparam logic [1:0] LHIO_MODE_3V3  = 2'h3;
  // Timing: one count unit is 40 ns, plus four extra clock periods.
  localparam int LHIO_CLK_NS      = 40;
  localparam int LHIO_UNIT_NS     = 40;
  localparam int LHIO_UNIT_CYC    = (LHIO_UNIT_NS + LHIO_CLK_NS - 1) / LHIO_CLK_NS;
  localparam int LHIO_EXTRA_UNITS = 4;
endpackage

// ---- rtl/lhio_regs.sv ----
// I/O control register bank with SCL low timer, status source selection and pin enables.
`timescale 1ns/1ps
// How it works
// - controller SCL low lasts 40ns times count plus four
// - target SDA setup uses same low count
// - low count resets to 0x7A
// - pass output chosen by bits 5:4
// - lock output chosen by bits 3:2
// - remote writes cannot change source fields
// - bits 1:0 enable receivers, reset one
// - bit 7 selects 1.8V or 3.3V levels
// - override bit picks detected or written values
// - without override, reads return detected level
// - supply mode 00 is 1.8V, 11 is 3.3V
// - status bits 6:0 show pin levels, bit7 zero
// - input enables bits 6:0 reset to one
module lhio_regs
  import lhio_pkg::*;
#(
  parameter int PIN_COUNT = 7
) (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Register access port; remote marks a control-channel access.
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic                 reg_remote,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  output logic                      reg_hit,
  // Receiver status from both ports.
  input  wire logic [1:0]           port_pass,
  input  wire logic [1:0]           port_lock,
  output logic                      pass_out,
  output logic                      lock_out,
  output logic                      first_receiver_enable,
  output logic                      second_receiver_enable,
  // Supply detection and I/O level outputs.
  input  wire logic                 detected_3v3,
  output logic                      high_level_io_select,
  output logic      [1:0]           supply_mode,
  // General-purpose pins.
  input  wire logic [PIN_COUNT-1:0] pin_level_in,
  output logic      [PIN_COUNT-1:0] pin_input_enable,
  // SCL low timing requests and done strobes.
  input  wire logic                 scl_low_start,
  input  wire logic                 sda_setup_start,
  output logic                      scl_low_busy,
  output logic                      scl_low_done,
  output logic                      sda_setup_done
);

  typedef enum logic [2:0] {
    LHIO_T_IDLE  = 3'b001,
    LHIO_T_LOW   = 3'b010,
    LHIO_T_SETUP = 3'b100
  } lhio_tstate_e;

  // Selects port 0 or port 1 status, or the any/all combination of the enabled ports, according to a two-bit code.
  function automatic logic lhio_pick(input logic [1:0] sel, input logic [1:0] st,
                                     input logic [1:0] en);
    logic r;
    r = 1'b0;
    unique case (sel)
      LHIO_SRC_PORT0: r = st[0];
      LHIO_SRC_PORT1: r = st[1];
      LHIO_SRC_ANY:   r = |(st & en);
      LHIO_SRC_ALL:   r = (en != 2'b00) && ((st & en) == en);
    endcase
    return r;
  endfunction

  // True when a write strobe addresses the given offset.
  function automatic logic lhio_wr_to(input logic wr, input logic [7:0] addr,
                                      input logic [7:0] off);
    return wr && (addr == off);
  endfunction

  logic [7:0]           scl_low_r,  scl_low_nxt;
  logic [1:0]           pass_sel_r, pass_sel_nxt;
  logic [1:0]           lock_sel_r, lock_sel_nxt;
  logic [1:0]           port_en_r,  port_en_nxt;
  logic                 sel_r,      sel_nxt;
  logic                 ovr_r,      ovr_nxt;
  logic [1:0]           mode_r,     mode_nxt;
  logic [3:0]           io_rsvd_r,  io_rsvd_nxt;
  logic [PIN_COUNT-1:0] inen_r,     inen_nxt;
  logic [PIN_COUNT-1:0] pin_s1_r,   pin_s2_r;
  logic                 det_s1_r,   det_s2_r;
  logic [1:0]           pass_s1_r,  pass_s2_r;
  logic [1:0]           lock_s1_r,  lock_s2_r;
  logic                 pass_r,     pass_nxt;
  logic                 lock_r,     lock_nxt;
  logic [7:0]           rdata_r,    rdata_nxt;
  logic                 hit_r,      hit_nxt;
  lhio_tstate_e         tst_r,      tst_nxt;
  logic [9:0]           tcnt_r,     tcnt_nxt;
  logic                 ldone_r,    ldone_nxt;
  logic                 sdone_r,    sdone_nxt;
  logic                 eff_sel;
  logic [1:0]           eff_mode;
  logic [9:0]           tload;

  // Detected level drives the controls unless override is set.
  always_comb begin
    eff_sel  = ovr_r ? sel_r  : det_s2_r;
    eff_mode = ovr_r ? mode_r : (det_s2_r ? LHIO_MODE_3V3 : LHIO_MODE_1V8);
  end

  // Low count, shared by the controller low time and the target setup time.
  always_comb begin
    scl_low_nxt = scl_low_r;
    if (lhio_wr_to(reg_wr, reg_addr, LHIO_OFF_SCL_LOW)) begin
      scl_low_nxt = reg_wdata;
    end
  end

  // Receiver control; a remote write reaches only the port enables.
  always_comb begin
    pass_sel_nxt = pass_sel_r;
    lock_sel_nxt = lock_sel_r;
    port_en_nxt  = port_en_r;
    if (lhio_wr_to(reg_wr, reg_addr, LHIO_OFF_RX_CTL)) begin
      if (!reg_remote) begin
        pass_sel_nxt = reg_wdata[LHIO_RX_PASS_LSB +: 2];
        lock_sel_nxt = reg_wdata[LHIO_RX_LOCK_LSB +: 2];
      end
      port_en_nxt = {reg_wdata[LHIO_RX_P1_BIT], reg_wdata[LHIO_RX_P0_BIT]};
    end
  end

  // I/O level control.
  always_comb begin
    sel_nxt     = sel_r;
    ovr_nxt     = ovr_r;
    mode_nxt    = mode_r;
    io_rsvd_nxt = io_rsvd_r;
    if (lhio_wr_to(reg_wr, reg_addr, LHIO_OFF_IO_LEVEL_CONTROL)) begin
      sel_nxt     = reg_wdata[LHIO_IO_SEL_BIT];
      ovr_nxt     = reg_wdata[LHIO_IO_OVR_BIT];
      mode_nxt    = reg_wdata[LHIO_IO_MODE_LSB +: 2];
      io_rsvd_nxt = reg_wdata[LHIO_IO_RSVD_LSB +: 4];
    end
  end

  // Pin input enables.
  always_comb begin
    inen_nxt = inen_r;
    if (lhio_wr_to(reg_wr, reg_addr, LHIO_OFF_PIN_INEN)) begin
      inen_nxt = reg_wdata[PIN_COUNT-1:0];
    end
  end

  // Read data and status outputs.
  always_comb begin
    rdata_nxt = 8'h00;
    hit_nxt   = 1'b0;
    if (reg_rd) begin
      hit_nxt = 1'b1;
      unique case (reg_addr)
        LHIO_OFF_SCL_LOW:  rdata_nxt = scl_low_r;
        LHIO_OFF_RX_CTL:   rdata_nxt = {LHIO_RST_RX_RSVD, pass_sel_r, lock_sel_r, port_en_r};
        LHIO_OFF_IO_LEVEL_CONTROL:   rdata_nxt = {eff_sel, ovr_r, eff_mode, io_rsvd_r};
        LHIO_OFF_PIN_STS:  rdata_nxt = 8'({1'b0, pin_s2_r});
        LHIO_OFF_PIN_INEN: rdata_nxt = 8'({1'b0, inen_r});
        default:           hit_nxt   = 1'b0;
      endcase
    end
  end

  // Pass and lock outputs follow the selected source.
  always_comb begin
    pass_nxt = lhio_pick(pass_sel_r, pass_s2_r, port_en_r);
    lock_nxt = lhio_pick(lock_sel_r, lock_s2_r, port_en_r);
  end

  // Timer: each count unit is one clock period, plus four extra periods.
  always_comb begin
    tload     = 10'((32'(scl_low_r) + LHIO_EXTRA_UNITS) * LHIO_UNIT_CYC);
    tst_nxt   = tst_r;
    tcnt_nxt  = tcnt_r;
    ldone_nxt = 1'b0;
    sdone_nxt = 1'b0;
    unique case (tst_r)
      LHIO_T_IDLE: begin
        if (scl_low_start) begin
          tst_nxt  = LHIO_T_LOW;
          tcnt_nxt = tload - 10'h001;
        end else if (sda_setup_start) begin
          tst_nxt  = LHIO_T_SETUP;
          tcnt_nxt = tload - 10'h001;
        end
      end
      LHIO_T_LOW, LHIO_T_SETUP: begin
        if (tcnt_r == 10'h000) begin
          tst_nxt   = LHIO_T_IDLE;
          ldone_nxt = (tst_r == LHIO_T_LOW);
          sdone_nxt = (tst_r == LHIO_T_SETUP);
        end else begin
          tcnt_nxt = tcnt_r - 10'h001;
        end
      end
      default: tst_nxt = LHIO_T_IDLE;
    endcase
  end

  // Two flops on every input from outside the clock domain; only the second is read.
  always_ff @(posedge clk) begin
    pin_s1_r  <= pin_level_in;
    pin_s2_r  <= pin_s1_r;
    det_s1_r  <= detected_3v3;
    det_s2_r  <= det_s1_r;
    pass_s1_r <= port_pass;
    pass_s2_r <= pass_s1_r;
    lock_s1_r <= port_lock;
    lock_s2_r <= lock_s1_r;
  end

  // Low count register.
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_low_r <= LHIO_RST_SCL_LOW;
    end else begin
      scl_low_r <= scl_low_nxt;
    end
  end

  // Receiver control register.
  always_ff @(posedge clk) begin
    if (rst) begin
      pass_sel_r <= LHIO_RST_SRC_SEL;
      lock_sel_r <= LHIO_RST_SRC_SEL;
      port_en_r  <= {LHIO_RST_PORT_EN, LHIO_RST_PORT_EN};
    end else begin
      pass_sel_r <= pass_sel_nxt;
      lock_sel_r <= lock_sel_nxt;
      port_en_r  <= port_en_nxt;
    end
  end

  // I/O level control register.
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_r     <= LHIO_RST_IO_SEL;
      ovr_r     <= LHIO_RST_IO_OVR;
      mode_r    <= LHIO_MODE_1V8;
      io_rsvd_r <= LHIO_RST_IO_RSVD;
    end else begin
      sel_r     <= sel_nxt;
      ovr_r     <= ovr_nxt;
      mode_r    <= mode_nxt;
      io_rsvd_r <= io_rsvd_nxt;
    end
  end

  // Pin input enable register.
  always_ff @(posedge clk) begin
    if (rst) begin
      inen_r <= LHIO_RST_INEN[PIN_COUNT-1:0];
    end else begin
      inen_r <= inen_nxt;
    end
  end

  // Registered read data and selected status outputs.
  always_ff @(posedge clk) begin
    if (rst) begin
      pass_r  <= 1'b0;
      lock_r  <= 1'b0;
      rdata_r <= 8'h00;
      hit_r   <= 1'b0;
    end else begin
      pass_r  <= pass_nxt;
      lock_r  <= lock_nxt;
      rdata_r <= rdata_nxt;
      hit_r   <= hit_nxt;
    end
  end

  // Interval timer; a start while it runs is ignored.
  always_ff @(posedge clk) begin
    if (rst) begin
      tst_r   <= LHIO_T_IDLE;
      tcnt_r  <= 10'h000;
      ldone_r <= 1'b0;
      sdone_r <= 1'b0;
    end else begin
      tst_r   <= tst_nxt;
      tcnt_r  <= tcnt_nxt;
      ldone_r <= ldone_nxt;
      sdone_r <= sdone_nxt;
    end
  end

  always_comb begin
    reg_rdata              = rdata_r;
    reg_hit                = hit_r;
    pass_out               = pass_r;
    lock_out               = lock_r;
    first_receiver_enable  = port_en_r[0];
    second_receiver_enable = port_en_r[1];
    high_level_io_select   = eff_sel;
    supply_mode            = eff_mode;
    pin_input_enable       = inen_r;
    scl_low_busy           = (tst_r == LHIO_T_LOW);
    scl_low_done           = ldone_r;
    sda_setup_done         = sdone_r;
  end

endmodule // lhio_regs

// ---- test/lhio_regs_properties.sv ----
// Checker with concurrent properties for the I/O control register bank.
`timescale 1ns/1ps
module lhio_regs_chk
  import lhio_pkg::*;
#(
  parameter int PIN_COUNT = 7
) (
  // Clock, reset and register read side.
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_addr,
  input wire logic [7:0]           reg_rdata,
  input wire logic                 reg_hit,
  // Control outputs and timer strobes.
  input wire logic                 first_receiver_enable,
  input wire logic                 second_receiver_enable,
  input wire logic                 high_level_io_select,
  input wire logic [1:0]           supply_mode,
  input wire logic [PIN_COUNT-1:0] pin_input_enable,
  input wire logic                 scl_low_busy,
  input wire logic                 scl_low_done,
  input wire logic                 sda_setup_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00 && !reg_hit; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
  property p_sts;
    $past(reg_rd && reg_addr == LHIO_OFF_PIN_STS) |-> reg_rdata[7] == 1'b0 && reg_hit;
  endproperty
  a_sts: assert property (p_sts) else $error("status bit 7 set");
  property p_mode; supply_mode == LHIO_MODE_1V8 || supply_mode == LHIO_MODE_3V3; endproperty
  a_mode: assert property (p_mode) else $error("reserved supply mode driven");
  property p_io;
    $past(reg_rd && reg_addr == LHIO_OFF_IO_LEVEL_CONTROL) |-> reg_rdata[7] == high_level_io_select
      && reg_rdata[5:4] == supply_mode;
  endproperty
  a_io: assert property (p_io) else $error("level read differs from level used");
  property p_rx;
    $past(reg_rd && reg_addr == LHIO_OFF_RX_CTL) |-> reg_rdata[7:6] == LHIO_RST_RX_RSVD
      && reg_rdata[1:0] == {second_receiver_enable, first_receiver_enable};
  endproperty
  a_rx: assert property (p_rx) else $error("receiver enables differ from read");
  property p_inen;
    $past(reg_rd && reg_addr == LHIO_OFF_PIN_INEN) |-> reg_rdata == {1'b0, pin_input_enable};
  endproperty
  a_inen: assert property (p_inen) else $error("input enables differ from read");
  property p_done_end; scl_low_done |-> $past(scl_low_busy) && !scl_low_busy; endproperty
  a_done_end: assert property (p_done_end) else $error("low done not at end of busy");
  property p_setup_pulse; sda_setup_done |=> !sda_setup_done; endproperty
  a_setup_pulse: assert property (p_setup_pulse) else $error("setup done over one cycle");
endmodule // lhio_regs_chk
bind lhio_regs lhio_regs_chk #(.PIN_COUNT(PIN_COUNT)) i_lhio_regs_chk (
  .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .reg_hit(reg_hit), .first_receiver_enable(first_receiver_enable),
  .second_receiver_enable(second_receiver_enable),
  .high_level_io_select(high_level_io_select), .supply_mode(supply_mode),
  .pin_input_enable(pin_input_enable), .scl_low_busy(scl_low_busy),
  .scl_low_done(scl_low_done), .sda_setup_done(sda_setup_done));

// ---- test/lhio_host_model.sv ----
// Controller model that issues local and remote register accesses.
`timescale 1ns/1ps
module lhio_host_model (
  // Clock.
  input wire logic       clk,
  // Register access port.
  output logic           reg_wr,
  output logic           reg_rd,
  output logic           reg_remote,
  output logic     [7:0] reg_addr,
  output logic     [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial {reg_wr, reg_rd, reg_remote, reg_addr, reg_wdata} = '0;
  // Callers keep reserved bits at reset values and never enable a pin as output.
  task automatic xfer(input logic w, input logic rem, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk);
    {reg_wr, reg_rd, reg_remote, reg_addr, reg_wdata} = {w, !w, rem, a, d};
    @(negedge clk);
    q = reg_rdata;
    {reg_wr, reg_rd, reg_remote, reg_addr, reg_wdata} = {2'b00, !rem, ~a, ~d};
  endtask
endmodule // lhio_host_model

// ---- test/link_hub_io_control_regs_tb_top.sv ----
// Self-checking testbench for the I/O control register bank.
`timescale 1ns/1ps
module link_hub_io_control_regs_tb_top;
  import lhio_pkg::*;
  logic clk = 0, rst = 1, reg_wr, reg_rd, reg_remote, pass_out, lock_out, fre, sre, hls, d3 = 1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic [1:0] pp = 2'h2, pl = 2'h1, smode;
  logic [6:0] pins = 7'h55, inen;
  logic sls = 0, sss = 0, busy, sld, ssd, hit;
  int errors = 0, n_checks = 0, cyc = 0, n;
  always #20 clk = ~clk;
  lhio_host_model i_lhio_host_model (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_remote(reg_remote), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  lhio_regs #(.PIN_COUNT(7)) i_lhio_regs (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_remote(reg_remote), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(hit), .port_pass(pp), .port_lock(pl), .pass_out(pass_out), .lock_out(lock_out),
    .first_receiver_enable(fre), .second_receiver_enable(sre), .detected_3v3(d3),
    .high_level_io_select(hls), .supply_mode(smode), .pin_level_in(pins),
    .pin_input_enable(inen), .scl_low_start(sls), .sda_setup_start(sss),
    .scl_low_busy(busy), .scl_low_done(sld), .sda_setup_done(ssd));
  task automatic check(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, exp);
    i_lhio_host_model.xfer(1'b0, 1'b0, a, 8'h00, q);
    check(q, exp);
  endtask
  task automatic wr(input logic rem, input logic [7:0] a, d);
    i_lhio_host_model.xfer(1'b1, rem, a, d, q);
  endtask
  task automatic t_reset_values;
    rd(LHIO_OFF_SCL_LOW, 8'h7A);
    rd(LHIO_OFF_RX_CTL, 8'h83);
    rd(LHIO_OFF_IO_LEVEL_CONTROL, 8'hB9);
    rd(LHIO_OFF_PIN_INEN, 8'h7F);
    rd(8'h20, 8'h00);
  endtask
  task automatic t_timer(input logic setup, input int exp);
    @(negedge clk);
    if (setup) sss = 1; else sls = 1;
    @(negedge clk);
    {sls, sss} = 2'b00;
    check({7'h0, busy}, {7'h0, !setup});
    n = 1;
    while (!(setup ? ssd : sld) && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(8'(n), 8'(exp));
  endtask
  task automatic t_sources;
    logic [1:0] c;
    logic [3:0] ep = 4'b0110, el = 4'b0101;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(1'b0, LHIO_OFF_RX_CTL, {2'h2, c, c, 2'h3});
      repeat (4) @(negedge clk);
      check({7'h0, pass_out}, {7'h0, ep[i]});
      check({7'h0, lock_out}, {7'h0, el[i]});
    end
    wr(1'b1, LHIO_OFF_RX_CTL, 8'h82);
    rd(LHIO_OFF_RX_CTL, 8'hBE);
    check({6'h0, sre, fre}, 8'h02);
    check({7'h0, pass_out}, 8'h01);
    wr(1'b0, LHIO_OFF_RX_CTL, 8'hAA);
    repeat (4) @(negedge clk);
    check({7'h0, pass_out}, 8'h01);
    check({7'h0, lock_out}, 8'h00);
  endtask
  task automatic t_levels;
    wr(1'b0, LHIO_OFF_IO_LEVEL_CONTROL, 8'h49);
    @(negedge clk);
    check({hls, 5'h0, smode}, 8'h00);
    rd(LHIO_OFF_IO_LEVEL_CONTROL, 8'h49);
    d3 = 1'b0;
    wr(1'b0, LHIO_OFF_IO_LEVEL_CONTROL, 8'h89);
    repeat (3) @(negedge clk);
    check({hls, 5'h0, smode}, 8'h00);
    rd(LHIO_OFF_IO_LEVEL_CONTROL, 8'h09);
    wr(1'b0, LHIO_OFF_IO_LEVEL_CONTROL, 8'hF9);
    @(negedge clk);
    check({hls, 5'h0, smode}, 8'h83);
    rd(LHIO_OFF_IO_LEVEL_CONTROL, 8'hF9);
    d3 = 1'b1;
    rd(LHIO_OFF_PIN_STS, 8'h55);
    pins = 7'h2A;
    repeat (3) @(negedge clk);
    rd(LHIO_OFF_PIN_STS, 8'h2A);
    wr(1'b0, LHIO_OFF_PIN_INEN, 8'h05);
    rd(LHIO_OFF_PIN_INEN, 8'h05);
    check({1'b0, inen}, 8'h05);
  endtask
  task automatic stop_test;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    repeat (3) @(negedge clk);
    t_reset_values();
    t_timer(1'b0, 127);
    wr(1'b0, LHIO_OFF_SCL_LOW, 8'h00);
    t_timer(1'b1, 5);
    t_sources();
    t_levels();
    rst = 1;
    repeat (4) @(negedge clk);
    rst = 0;
    repeat (3) @(negedge clk);
    t_reset_values();
    stop_test();
  end
endmodule // link_hub_io_control_regs_tb_top
